// *** src/cia_cfg.svh ***
// constants for the core indirect access bridge: offsets, bit positions, reset values
`ifndef CIA_CFG_SVH
`define CIA_CFG_SVH

`define CIA_OFF_STATUS 8'h00
`define CIA_OFF_ADDR 8'h04
`define CIA_OFF_DATA 8'h08
`define CIA_OFF_INCR 8'h0c
`define CIA_OFF_PASSIVE 8'h10

`define CIA_BIT_PENDING 0
`define CIA_BIT_ERROR 1
`define CIA_BIT_PEND_RD 2
`define CIA_BIT_ERR_RD 3

`define CIA_MARKER 32'h80000000
`define CIA_ADDR_STEP 32'h00000004
`define CIA_RST_WORD 32'h00000000
`define CIA_FULL_SEL 4'hf

`endif

// *** src/cia_pkg.sv ***
// types shared by the core indirect access bridge and its shared-bus master
`default_nettype none

package cia_pkg;

    typedef enum logic [2:0] {
        CIA_VIEW_STATUS,
        CIA_VIEW_ADDR,
        CIA_VIEW_DATA,
        CIA_VIEW_INCR,
        CIA_VIEW_PASSIVE,
        CIA_VIEW_NONE
    } cia_view_e;

    typedef enum logic {
        CIA_SBM_IDLE,
        CIA_SBM_REQ
    } cia_sbm_e;

    typedef struct packed {
        cia_sbm_e st;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] wdat;
        logic done;
        logic err;
        logic [31:0] rdat;
    } cia_sbm_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [31:0] addr;
        logic [31:0] data;
        logic busy;
        logic err;
        logic pend_rd;
        logic err_rd;
        logic start;
        logic start_we;
        logic [31:0] start_adr;
        logic [31:0] start_dat;
    } cia_core_s;

endpackage : cia_pkg

`default_nettype wire

// *** src/cia_sb_master.sv ***
// dedicated master on the internal shared bus: one full-word transfer per start pulse
`default_nettype none

module cia_sb_master
    import cia_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic sb_cyc_o,
    output logic sb_stb_o,
    output logic sb_we_o,
    output logic [31:0] sb_adr_o,
    output logic [3:0] sb_sel_o,
    output logic [31:0] sb_dat_o,
    input wire logic sb_ack_i,
    input wire logic sb_err_i,
    input wire logic [31:0] sb_dat_i,
    output logic done_o,
    output logic err_o,
    output logic [31:0] rdat_o
);
    `include "cia_cfg.svh"

    cia_sbm_s s;
    cia_sbm_s next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            CIA_SBM_IDLE: begin
                if (start_i) begin
                    next_s.st = CIA_SBM_REQ;
                    next_s.we = we_i;
                    next_s.adr = adr_i;
                    next_s.wdat = dat_i;
                    next_s.sel = `CIA_FULL_SEL;
                end
            end
            CIA_SBM_REQ: begin
                // arbitration stalls us here until the bus answers
                if (sb_ack_i || sb_err_i) begin
                    next_s.st = CIA_SBM_IDLE;
                    next_s.done = 1'b1;
                    next_s.err = sb_err_i;
                    next_s.rdat = sb_dat_i;
                    next_s.sel = 4'h0;
                end
            end
            default: begin
                next_s.st = CIA_SBM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sb_cyc_o = (s.st == CIA_SBM_REQ);
    assign sb_stb_o = (s.st == CIA_SBM_REQ);
    assign sb_we_o = s.we;
    assign sb_adr_o = s.adr;
    assign sb_sel_o = s.sel;
    assign sb_dat_o = s.wdat;
    assign done_o = s.done;
    assign err_o = s.err;
    assign rdat_o = s.rdat;

endmodule : cia_sb_master

`default_nettype wire

// *** src/cia_bridge.sv ***
// core indirect access bridge: wishbone register slave driving a shared-bus master
//
// Operation
// - Only full-word 32-bit reads and writes are carried out on the shared bus.
// - Transfers go out through a dedicated shared-bus master that waits for arbitration.
// - Each transfer targets the byte address held in the software-written address register.
// - Writing the primary data window with no transfer pending stores the word and starts a shared-bus write of it.
// - Reading the primary data window with no transfer pending returns the held word, starts a read, and loads the result.
// - The auto-increment window acts as the primary one and then adds 4 to the address register.
// - The passive window reads and writes the held word and never starts a transfer.
// - A transfer ending in error sets the error flag and forces the held word to 0x80000000.
// - Every data window reads 0x80000000 while a transfer is pending.
// - A flag records whether a transfer was pending when a data window was last read.
// - A marker read with pending-at-read and error-at-read both clear is genuine data.
// - Auto-increment reads that hit a pending transfer leave the address unchanged.
`default_nettype none

module cia_bridge
    import cia_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic sb_cyc_o,
    output logic sb_stb_o,
    output logic sb_we_o,
    output logic [31:0] sb_adr_o,
    output logic [3:0] sb_sel_o,
    output logic [31:0] sb_dat_o,
    input wire logic sb_ack_i,
    input wire logic sb_err_i,
    input wire logic [31:0] sb_dat_i
);
    `include "cia_cfg.svh"

    function automatic cia_view_e cia_decode(input logic [7:0] adr);
        cia_view_e v;
        if (adr == `CIA_OFF_STATUS) begin
            v = CIA_VIEW_STATUS;
        end else if (adr == `CIA_OFF_ADDR) begin
            v = CIA_VIEW_ADDR;
        end else if (adr == `CIA_OFF_DATA) begin
            v = CIA_VIEW_DATA;
        end else if (adr == `CIA_OFF_INCR) begin
            v = CIA_VIEW_INCR;
        end else if (adr == `CIA_OFF_PASSIVE) begin
            v = CIA_VIEW_PASSIVE;
        end else begin
            v = CIA_VIEW_NONE;
        end
        return v;
    endfunction : cia_decode

    function automatic logic cia_is_window(input cia_view_e v);
        return (v == CIA_VIEW_DATA) || (v == CIA_VIEW_INCR) || (v == CIA_VIEW_PASSIVE);
    endfunction : cia_is_window

    // byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] cia_merge(
        input logic [31:0] old,
        input logic [31:0] wr,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = wr[8*i +: 8];
            end
        end
        return res;
    endfunction : cia_merge

    cia_core_s s;
    cia_core_s next_s;
    logic take;
    cia_view_e view;
    logic sbm_done;
    logic sbm_err;
    logic [31:0] sbm_rdat;
    logic [31:0] merged;

    assign take = wb_cyc_i && wb_stb_i && !s.ack;
    assign view = cia_decode(wb_adr_i);
    assign merged = cia_merge(s.data, wb_dat_i, wb_sel_i);

    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.start = 1'b0;
        if (take) begin
            next_s.ack = 1'b1;
            next_s.rdat = '0;
            if (!wb_we_i) begin
                if (view == CIA_VIEW_STATUS) begin
                    next_s.rdat[`CIA_BIT_PENDING] = s.busy;
                    next_s.rdat[`CIA_BIT_ERROR] = s.err;
                    next_s.rdat[`CIA_BIT_PEND_RD] = s.pend_rd;
                    next_s.rdat[`CIA_BIT_ERR_RD] = s.err_rd;
                end else if (view == CIA_VIEW_ADDR) begin
                    next_s.rdat = s.addr;
                end else if (cia_is_window(view)) begin
                    next_s.rdat = s.busy ? `CIA_MARKER : s.data;
                    next_s.pend_rd = s.busy;
                    next_s.err_rd = s.err;
                    if (!s.busy && view != CIA_VIEW_PASSIVE) begin
                        next_s.busy = 1'b1;
                        next_s.start = 1'b1;
                        next_s.start_we = 1'b0;
                        next_s.start_adr = s.addr;
                    end
                end
            end else begin
                if (view == CIA_VIEW_STATUS) begin
                    if (wb_sel_i[0] && wb_dat_i[`CIA_BIT_ERROR]) begin
                        next_s.err = 1'b0;
                    end
                end else if (view == CIA_VIEW_ADDR) begin
                    next_s.addr = cia_merge(s.addr, wb_dat_i, wb_sel_i);
                end else if (cia_is_window(view) && !s.busy) begin
                    next_s.data = merged;
                    if (view != CIA_VIEW_PASSIVE) begin
                        next_s.busy = 1'b1;
                        next_s.start = 1'b1;
                        next_s.start_we = 1'b1;
                        next_s.start_adr = s.addr;
                        next_s.start_dat = merged;
                    end
                end
            end
            if (view == CIA_VIEW_INCR && !s.busy) begin
                next_s.addr = s.addr + `CIA_ADDR_STEP;
            end
        end
        if (s.busy && sbm_done) begin
            next_s.busy = 1'b0;
            if (sbm_err) begin
                next_s.err = 1'b1;
                next_s.data = `CIA_MARKER;
            end else if (!s.start_we) begin
                next_s.data = sbm_rdat;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;

    cia_sb_master u_master (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(s.start),
        .we_i(s.start_we),
        .adr_i(s.start_adr),
        .dat_i(s.start_dat),
        .sb_cyc_o(sb_cyc_o),
        .sb_stb_o(sb_stb_o),
        .sb_we_o(sb_we_o),
        .sb_adr_o(sb_adr_o),
        .sb_sel_o(sb_sel_o),
        .sb_dat_o(sb_dat_o),
        .sb_ack_i(sb_ack_i),
        .sb_err_i(sb_err_i),
        .sb_dat_i(sb_dat_i),
        .done_o(sbm_done),
        .err_o(sbm_err),
        .rdat_o(sbm_rdat)
    );

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_full_word;
        sb_cyc_o |-> sb_sel_o == `CIA_FULL_SEL;
    endproperty
    a_full_word: assert property (p_full_word) else $error("shared bus transfer not full word");

    property p_launch;
        s.start |-> ##[1:2] sb_cyc_o;
    endproperty
    a_launch: assert property (p_launch) else $error("master did not request the shared bus");

    property p_addr_src;
        s.start |=> sb_adr_o == $past(s.start_adr) && sb_cyc_o;
    endproperty
    a_addr_src: assert property (p_addr_src) else $error("shared bus address not from address register");

    property p_write_start;
        take && wb_we_i && view == CIA_VIEW_DATA && !s.busy && wb_sel_i == 4'hf
            |=> s.start && s.start_we && s.start_dat == $past(wb_dat_i) && s.data == $past(wb_dat_i);
    endproperty
    a_write_start: assert property (p_write_start) else $error("window write did not start write");

    property p_read_load;
        s.busy && sbm_done && !sbm_err && !s.start_we |=> s.data == $past(sbm_rdat);
    endproperty
    a_read_load: assert property (p_read_load) else $error("read result not loaded");

    property p_incr;
        take && view == CIA_VIEW_INCR && !s.busy |=> s.addr == $past(s.addr) + `CIA_ADDR_STEP && s.busy;
    endproperty
    a_incr: assert property (p_incr) else $error("auto-increment did not add four");

    property p_passive;
        take && view == CIA_VIEW_PASSIVE |=> !s.start ##1 !sb_cyc_o || $past(sb_cyc_o);
    endproperty
    a_passive: assert property (p_passive) else $error("passive window started a transfer");

    property p_err_marker;
        s.busy && sbm_done && sbm_err |=> s.data == `CIA_MARKER && s.err && !s.busy;
    endproperty
    a_err_marker: assert property (p_err_marker) else $error("error did not force marker");

    property p_busy_marker;
        take && !wb_we_i && cia_is_window(view) && s.busy |=> wb_ack_o && wb_dat_o == `CIA_MARKER && s.pend_rd;
    endproperty
    a_busy_marker: assert property (p_busy_marker) else $error("busy window read not marker");

    property p_pend_rd;
        take && !wb_we_i && cia_is_window(view) |=> s.pend_rd == $past(s.busy) && s.err_rd == $past(s.err);
    endproperty
    a_pend_rd: assert property (p_pend_rd) else $error("at-read flags not captured");

    property p_busy_noinc;
        take && view == CIA_VIEW_INCR && s.busy |=> $stable(s.addr) && !s.start;
    endproperty
    a_busy_noinc: assert property (p_busy_noinc) else $error("address moved on busy read");

    property p_busy_clear;
        s.busy && sbm_done |=> !s.busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared on completion");

    property p_ack_answer;
        take |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("register access not acknowledged");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");

    property p_unmapped;
        take && view == CIA_VIEW_NONE |=> wb_ack_o && wb_dat_o == 32'h0 && !s.start;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped offset not answered with zero");

    property p_sel_idle;
        !sb_cyc_o |-> sb_sel_o == 4'h0;
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("byte enables active while idle");

    property p_sb_hold;
        sb_cyc_o && !sb_ack_i && !sb_err_i
            |=> sb_cyc_o && $stable(sb_adr_o) && $stable(sb_we_o) && $stable(sb_dat_o);
    endproperty
    a_sb_hold: assert property (p_sb_hold) else $error("shared bus request changed while stalled");

    property p_sb_release;
        sb_cyc_o && (sb_ack_i || sb_err_i) |=> !sb_cyc_o && sb_sel_o == 4'h0;
    endproperty
    a_sb_release: assert property (p_sb_release) else $error("shared bus request held after answer");

    property p_addr_write;
        take && wb_we_i && view == CIA_VIEW_ADDR && wb_sel_i == `CIA_FULL_SEL |=> s.addr == $past(wb_dat_i);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("address register write lost");

    property p_write_data;
        sb_cyc_o && sb_we_o |-> sb_dat_o == s.start_dat;
    endproperty
    a_write_data: assert property (p_write_data) else $error("shared bus write data not the written word");

    property p_busy_drop;
        take && wb_we_i && cia_is_window(view) && s.busy && !sbm_done
            |=> !s.start && s.data == $past(s.data);
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("window write accepted while busy");

    property p_stale_read;
        take && !wb_we_i && cia_is_window(view) && !s.busy |=> wb_dat_o == $past(s.data);
    endproperty
    a_stale_read: assert property (p_stale_read) else $error("idle window read not the held word");

    property p_passive_write;
        take && wb_we_i && view == CIA_VIEW_PASSIVE && !s.busy |=> s.data == $past(merged) && !s.start;
    endproperty
    a_passive_write: assert property (p_passive_write) else $error("passive write wrong");

    property p_err_sticky;
        s.err && !(take && wb_we_i && view == CIA_VIEW_STATUS && wb_sel_i[0] && wb_dat_i[`CIA_BIT_ERROR])
            |=> s.err;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag cleared without software");

    property p_status_read;
        take && !wb_we_i && view == CIA_VIEW_STATUS
            |=> wb_dat_o == {28'h0, $past(s.err_rd), $past(s.pend_rd), $past(s.err), $past(s.busy)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_genuine;
        take && !wb_we_i && cia_is_window(view) && !s.busy && !s.err && s.data == `CIA_MARKER
            |=> wb_dat_o == `CIA_MARKER && !s.pend_rd && !s.err_rd;
    endproperty
    a_genuine: assert property (p_genuine) else $error("genuine marker read flagged");

    property p_single;
        s.start |-> s.busy && !sb_cyc_o;
    endproperty
    a_single: assert property (p_single) else $error("launch without busy or over a live request");

    property p_busy_hold;
        s.busy && !sbm_done |=> s.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy fell before completion");

    c_read_cycle: cover property (s.start && !s.start_we ##[1:20] sbm_done && !sbm_err);
    c_write_cycle: cover property (s.start && s.start_we ##[1:20] sbm_done);
    c_busy_read: cover property (take && !wb_we_i && view == CIA_VIEW_INCR && s.busy);
    c_error: cover property (sbm_done && sbm_err);
    c_genuine: cover property (take && !wb_we_i && cia_is_window(view) && !s.busy && s.data == `CIA_MARKER);

endmodule : cia_bridge

`default_nettype wire

// *** test/cia_sb_slave_model.sv ***
// shared-bus slave model: word memory, settable answer delay, one erroring address
`default_nettype none

module cia_sb_slave_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sb_cyc_i,
    input wire logic sb_stb_i,
    input wire logic sb_we_i,
    input wire logic [31:0] sb_adr_i,
    input wire logic [31:0] sb_dat_i,
    input wire logic [3:0] delay_i,
    input wire logic [31:0] err_adr_i,
    output logic sb_ack_o,
    output logic sb_err_o,
    output logic [31:0] sb_dat_o,
    output logic [7:0] xfers_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [16];
    logic [3:0] cnt;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 4'h0;
            sb_ack_o <= 1'b0;
            sb_err_o <= 1'b0;
            sb_dat_o <= 32'h0;
            xfers_o <= 8'h0;
        end else begin
            sb_ack_o <= 1'b0;
            sb_err_o <= 1'b0;
            // released data lines keep changing
            sb_dat_o <= ~sb_dat_o;
            if (sb_cyc_i && sb_stb_i && !sb_ack_o && !sb_err_o) begin
                if (cnt == delay_i) begin
                    cnt <= 4'h0;
                    xfers_o <= xfers_o + 8'h1;
                    if (sb_adr_i == err_adr_i) begin
                        sb_err_o <= 1'b1;
                    end else begin
                        sb_ack_o <= 1'b1;
                        if (sb_we_i) begin
                            mem[sb_adr_i[5:2]] <= sb_dat_i;
                        end else begin
                            sb_dat_o <= mem[sb_adr_i[5:2]];
                        end
                    end
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule : cia_sb_slave_model

`default_nettype wire

// *** test/cia_bridge_tb.sv ***
// self-checking bench for the indirect access bridge
`default_nettype none

module cia_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic sb_cyc_o, sb_stb_o, sb_we_o, sb_ack, sb_err;
    logic [31:0] sb_adr_o, sb_dat_o, sb_rdat, rd;
    logic [3:0] sb_sel_o;
    logic [3:0] delay = 4'h3;
    logic [31:0] err_adr = 32'h40;
    logic [7:0] xfers;
    int errors = 0;
    int checks = 0;
    logic [31:0] got;
    int tries = 0;

    always #5 clk_i = ~clk_i;

    cia_bridge DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .sb_cyc_o(sb_cyc_o), .sb_stb_o(sb_stb_o), .sb_we_o(sb_we_o), .sb_adr_o(sb_adr_o),
        .sb_sel_o(sb_sel_o), .sb_dat_o(sb_dat_o), .sb_ack_i(sb_ack), .sb_err_i(sb_err), .sb_dat_i(sb_rdat));

    cia_sb_slave_model partner (.clk_i(clk_i), .rst_i(rst_i), .sb_cyc_i(sb_cyc_o), .sb_stb_i(sb_stb_o),
        .sb_we_i(sb_we_o), .sb_adr_i(sb_adr_o), .sb_dat_i(sb_dat_o), .delay_i(delay), .err_adr_i(err_adr),
        .sb_ack_o(sb_ack), .sb_err_o(sb_err), .sb_dat_o(sb_rdat), .xfers_o(xfers));

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            tally_and_finish();
        end
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdc

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, 8'h00, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            tally_and_finish();
        end
    endtask : wait_idle

    always @(posedge clk_i) if (sb_cyc_o === 1'b1) chk("sb_sel", {28'h0, sb_sel_o}, 32'hf);

    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        tally_and_finish();
    end

    initial begin
        partner.mem[3] = 32'hcafe0003;
        partner.mem[4] = 32'hcafe0004;
        partner.mem[5] = 32'h80000000;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("status", 8'h00, 32'h0);
        rdc("addr", 8'h04, 32'h0);
        rdc("unmapped", 8'h14, 32'h0);
        wb(1'b1, 8'h04, 32'h8);
        wb(1'b1, 8'h08, 32'h11223344);
        rdc("status busy", 8'h00, 32'h1);
        wait_idle();
        chk("sb written", partner.mem[2], 32'h11223344);
        wb(1'b1, 8'h04, 32'hc);
        rdc("stale", 8'h08, 32'h11223344);
        rdc("busy marker", 8'h10, 32'h80000000);
        rdc("pend_rd", 8'h00, 32'h5);
        wait_idle();
        rdc("loaded", 8'h10, 32'hcafe0003);
        rdc("pend_rd clr", 8'h00, 32'h0);
        wb(1'b1, 8'h04, 32'h10);
        rdc("incr stale", 8'h0c, 32'hcafe0003);
        rdc("incr busy", 8'h0c, 32'h80000000);
        rdc("addr step", 8'h04, 32'h14);
        wait_idle();
        rdc("incr loaded", 8'h0c, 32'hcafe0004);
        rdc("addr step2", 8'h04, 32'h18);
        wait_idle();
        chk("xfers", {24'h0, xfers}, 32'h4);
        wb(1'b1, 8'h10, 32'h5a5a0000);
        rdc("passive", 8'h10, 32'h5a5a0000);
        repeat (8) @(posedge clk_i);
        chk("no launch", {24'h0, xfers}, 32'h4);
        wb(1'b1, 8'h04, 32'h40);
        rdc("err stale", 8'h08, 32'h5a5a0000);
        wait_idle();
        rdc("err flag", 8'h00, 32'h2);
        rdc("err data", 8'h10, 32'h80000000);
        rdc("err_rd", 8'h00, 32'ha);
        wb(1'b1, 8'h00, 32'h2);
        rdc("err clr", 8'h00, 32'h8);
        wb(1'b1, 8'h04, 32'h14);
        delay <= 4'h0;
        wb(1'b0, 8'h08, 32'h0);
        wait_idle();
        rdc("genuine", 8'h10, 32'h80000000);
        rdc("flags clr", 8'h00, 32'h0);
        // read at once, retry on marker
        delay <= 4'h3;
        wb(1'b1, 8'h04, 32'hc);
        wb(1'b0, 8'h08, 32'h0);
        wb(1'b1, 8'h10, 32'h12345678);
        do begin
            wb(1'b0, 8'h10, 32'h0);
            got = rd;
            if (got == 32'h80000000) begin
                wb(1'b0, 8'h00, 32'h0);
            end
            tries++;
        end while (got == 32'h80000000 && rd[2] === 1'b1 && tries < 8);
        chk("retry data", got, 32'hcafe0003);
        chk("retry count", tries, 32'h2);
        tally_and_finish();
    end
endmodule : cia_bridge_tb

`default_nettype wire
